// ---- verilog/spi_port.sv ----
// spi_port: 8-bit master/slave serial port behind an APB register slave
// assumes APB on MCLK; serial pins are asynchronous and pass pin_sync
//
// Summary of operation
// - one 8-bit full-duplex word per transfer
// - master drives clock; slave takes clock, select
// - enable bit clear: port idle, pins released
// - polarity bit sets clock rest level
// - edge bit picks data change edge
// - phase bit picks middle or end sampling
// - 2-bit mode picks master source or slave
// - modes: 00 slow, 01 cpu, 10/11 slave
// - polarity 1 idles high, 0 idles low
// - edge 1 changes data on trailing edge
// - master: buffer write starts a transfer
// - after 8 bits: buffer, full, flag set
// - buffer holds last word until next completes
// - reading buffer clears full flag
// - slave word while full: overflow, word discarded
// - overflow sticky, never set as master
// - busy during transfer; buffer writes ignored
// - slave clock comes from master, idle first
// - slave drives out while capturing in
// - sleep plus interrupt enable: wake on word
// - select high releases data-out, no transfer
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
module spi_port #(
	parameter int CPU_HALF = spi_port_pkg::CPU_HALF_CYC, // mclk cycles per sck half, cpu clock
	parameter int LS_HALF  = spi_port_pkg::LS_HALF_CYC   // mclk cycles per sck half, slow clock
) (
	input  wire logic        MCLK,    // system clock, 100 MHz
	input  wire logic        RESET,   // synchronous reset, active high
	input  wire logic        PSEL,    // apb select
	input  wire logic        PENABLE, // apb access phase
	input  wire logic        PWRITE,  // apb direction
	input  wire logic [7:0]  PADDR,   // apb byte address
	input  wire logic [31:0] PWDATA,  // apb write data
	output logic      [31:0] PRDATA,  // apb read data
	output logic             PREADY,  // apb ready
	output logic             PSLVERR, // apb error on unmapped address
	input  wire logic        SLEEP,   // device is in sleep mode
	output logic             WAKE,    // wake request
	input  wire logic        SCK_I,   // serial clock pin in
	output logic             SCK_O,   // serial clock pin out
	output logic             SCK_OE,  // serial clock drive enable
	input  wire logic        SDI,     // serial data in
	output logic             SDO_O,   // serial data out
	output logic             SDO_OE,  // serial data drive enable
	input  wire logic        SCE_N    // slave select, active low
);
	// parameters the divider cannot serve are refused
	generate
		if (CPU_HALF < spi_port_pkg::SYNC_HALF_MIN || LS_HALF < spi_port_pkg::SYNC_HALF_MIN
			|| CPU_HALF > 65535 || LS_HALF > 65535) begin : g_chk
			$error("spi_port: half period counts out of range");
		end
	endgenerate

	logic [7:0]  ctrl_q;
	logic [7:0]  buf_q;
	logic [7:0]  tx_q;
	logic [7:0]  rx_q;
	logic [7:0]  rx_next;
	logic [7:0]  word_in;
	logic [7:0]  rd_mux;
	logic [3:0]  bit_cnt_q;
	logic [4:0]  half_q;
	logic [15:0] div_q;
	logic [15:0] div_end;
	logic        bf_q, ov_q, if_q, ie_q;
	logic        sdo_q, sck_o_q, sck_oe_q, sdo_oe_q, wake_q;
	logic        pready_q, pslverr_q;
	logic [31:0] prdata_q;
	logic        sck_s, sdi_s, sce_n_s, sck_prev_q;
	logic        en, clock_idle_polarity, cke, input_sample_phase, is_master, is_slave, sel_mode, slave_active;
	logic        acc, done, wr_buf, rd_buf, mapped, busy;
	logic        lead, trail, tick, m_chg, m_smp, m_done, s_chg, s_smp, s_done;
	logic        sample, done_word;
	spi_port_pkg::state_type state_q;

	// control decode
	assign en        = ctrl_q[spi_port_pkg::CTRL_EN_BIT];
	assign clock_idle_polarity       = ctrl_q[spi_port_pkg::CTRL_CKP_BIT];
	assign cke       = ctrl_q[spi_port_pkg::CTRL_CKE_BIT];
	assign input_sample_phase       = ctrl_q[spi_port_pkg::CTRL_SMP_BIT];
	assign is_master = en & ~ctrl_q[spi_port_pkg::CTRL_MODE_LSB+1];
	assign is_slave  = en & ctrl_q[spi_port_pkg::CTRL_MODE_LSB+1];
	assign sel_mode  = ctrl_q[spi_port_pkg::CTRL_MODE_LSB+1 -: 2] == spi_port_pkg::MODE_SLAVE_SEL;
	assign slave_active = is_slave & (~sel_mode | ~sce_n_s);
	assign busy      = state_q != spi_port_pkg::ST_IDLE;

	// pin inputs cross into mclk; select idles released, clock at rest low
	pin_sync #(.W(3)) u_sync (
		.clk     (MCLK),
		.rst     (RESET),
		.rst_val (3'h4),
		.d       ({SCE_N, SCK_I, SDI}),
		.q       ({sce_n_s, sck_s, sdi_s})
	);

	// apb: access phase answered one cycle late, effects at the completing edge
	assign acc    = PSEL & PENABLE & ~pready_q;
	assign done   = PSEL & PENABLE & pready_q;
	assign wr_buf = done & PWRITE & (PADDR == spi_port_pkg::BUF_OFS);
	assign rd_buf = done & ~PWRITE & (PADDR == spi_port_pkg::BUF_OFS);
	assign mapped = PADDR == spi_port_pkg::CTRL_OFS || PADDR == spi_port_pkg::STAT_OFS
		|| PADDR == spi_port_pkg::BUF_OFS || PADDR == spi_port_pkg::INTC_OFS;

	// read mux; reserved bits read as zero
	always_comb begin
		rd_mux = 8'h00;
		case (PADDR)
			spi_port_pkg::CTRL_OFS: rd_mux = ctrl_q;
			spi_port_pkg::STAT_OFS: rd_mux = {busy, ov_q, 5'h00, bf_q};
			spi_port_pkg::BUF_OFS:  rd_mux = buf_q;
			spi_port_pkg::INTC_OFS: rd_mux = {6'h00, if_q, ie_q};
			default:                rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h00000000;
		end else begin
			pready_q  <= acc;
			pslverr_q <= acc & ~mapped;
			if (acc) begin
				prdata_q <= {24'h000000, rd_mux};
			end
		end
	end

	// control register
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			ctrl_q <= spi_port_pkg::CTRL_RESET;
		end else if (done && PWRITE && PADDR == spi_port_pkg::CTRL_OFS) begin
			ctrl_q <= PWDATA[7:0] & spi_port_pkg::CTRL_MASK;
		end
	end

	// serial clock edges seen on the filtered pin
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			sck_prev_q <= 1'b0;
		end else begin
			sck_prev_q <= sck_s;
		end
	end
	assign lead  = (sck_s != sck_prev_q) && (sck_prev_q == clock_idle_polarity);
	assign trail = (sck_s != sck_prev_q) && (sck_prev_q != clock_idle_polarity);

	// master divider: slow or processor clock source
	assign div_end = ctrl_q[spi_port_pkg::CTRL_MODE_LSB] ? 16'(CPU_HALF - 1)
		: 16'(LS_HALF - 1);
	assign tick = (state_q == spi_port_pkg::ST_MASTER) && (div_q == div_end);
	always_ff @(posedge MCLK) begin
		if (RESET || state_q != spi_port_pkg::ST_MASTER || tick) begin
			div_q <= 16'h0000;
		end else begin
			div_q <= div_q + 16'h0001;
		end
	end

	// master events by half step: even steps lead, odd steps trail
	assign m_chg  = tick && (half_q[0] == cke) && (half_q < 5'(spi_port_pkg::HALF_STEPS));
	// mid sampling with cke 1 uses step zero as well; end sampling skips it, no change edge came before
	assign m_smp  = tick && (input_sample_phase ? (half_q[0] == cke) && (half_q != 5'h00)
		: (half_q[0] != cke) && (half_q < 5'(spi_port_pkg::HALF_STEPS)));
	assign m_done = tick && (half_q == 5'(spi_port_pkg::HALF_STEPS));
	// slave: change on the chosen edge, sample on the other one
	assign s_chg  = slave_active && (cke ? trail : lead);
	assign s_smp  = slave_active && (cke ? lead : trail);
	assign s_done = s_smp && (bit_cnt_q == 4'(spi_port_pkg::WORD_BITS - 1));
	assign sample    = m_smp | s_smp;
	assign done_word = m_done | s_done;
	assign rx_next   = {rx_q[6:0], sdi_s};
	assign word_in   = sample ? rx_next : rx_q;

	// transfer state; disabling or releasing select abandons a partial word
	always_ff @(posedge MCLK) begin
		if (RESET || !en) begin
			state_q <= spi_port_pkg::ST_IDLE;
		end else begin
			case (state_q)
				spi_port_pkg::ST_IDLE: begin
					if (wr_buf && is_master) begin
						state_q <= spi_port_pkg::ST_MASTER;
					end else if (slave_active && lead) begin
						// a trailing edge while idle is the tail of the last frame, not a start
						state_q <= spi_port_pkg::ST_SLAVE;
					end
				end
				spi_port_pkg::ST_MASTER: begin
					if (m_done || !is_master) begin
						state_q <= spi_port_pkg::ST_IDLE;
					end
				end
				spi_port_pkg::ST_SLAVE: begin
					if (s_done || !slave_active) begin
						state_q <= spi_port_pkg::ST_IDLE;
					end
				end
				default: state_q <= spi_port_pkg::ST_IDLE;
			endcase
		end
	end

	// bit and half-step counters
	always_ff @(posedge MCLK) begin
		if (RESET || !en || state_q == spi_port_pkg::ST_IDLE && !(slave_active && s_smp)) begin
			bit_cnt_q <= 4'h0;
			half_q    <= 5'h00;
		end else begin
			if (sample) begin
				bit_cnt_q <= done_word ? 4'h0 : bit_cnt_q + 4'h1;
			end
			if (tick) begin
				half_q <= half_q + 5'h01;
			end
			if (s_done || (state_q == spi_port_pkg::ST_SLAVE && !slave_active)) begin
				bit_cnt_q <= 4'h0;
			end
		end
	end

	// shift registers, msb first; a write while busy never reaches them
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			tx_q  <= 8'h00;
			rx_q  <= 8'h00;
			sdo_q <= 1'b0;
		end else begin
			if (wr_buf && !busy && en) begin
				tx_q <= cke ? {PWDATA[6:0], 1'b0} : PWDATA[7:0];
				if (cke) begin
					sdo_q <= PWDATA[7];
				end
			end else if (m_chg || s_chg) begin
				sdo_q <= tx_q[7];
				tx_q  <= {tx_q[6:0], 1'b0};
			end
			if (sample) begin
				rx_q <= rx_next;
			end
		end
	end

	// buffer: only completed words land; software writes go to the shifter alone
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			buf_q <= spi_port_pkg::BUF_RESET;
		end else if (done_word && !(bf_q && is_slave)) begin
			buf_q <= word_in;
		end
	end

	// status flags: hardware set wins over the software clear
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			bf_q <= 1'b0;
			ov_q <= 1'b0;
			if_q <= 1'b0;
			ie_q <= 1'b0;
		end else begin
			if (done_word && !(bf_q && is_slave)) begin
				bf_q <= 1'b1;
			end else if (rd_buf) begin
				bf_q <= 1'b0;
			end
			if (done_word && bf_q && is_slave) begin
				ov_q <= 1'b1;
			end else if (done && PWRITE && PADDR == spi_port_pkg::STAT_OFS
				&& !PWDATA[spi_port_pkg::STAT_OV_BIT]) begin
				ov_q <= 1'b0;
			end
			if (done_word) begin
				if_q <= 1'b1;
			end else if (done && PWRITE && PADDR == spi_port_pkg::INTC_OFS
				&& !PWDATA[spi_port_pkg::INTC_IF_BIT]) begin
				if_q <= 1'b0;
			end
			if (done && PWRITE && PADDR == spi_port_pkg::INTC_OFS) begin
				ie_q <= PWDATA[spi_port_pkg::INTC_IE_BIT];
			end
		end
	end

	// pin drivers; the clock rests at the polarity level outside transfers
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			sck_o_q  <= 1'b0;
			sck_oe_q <= 1'b0;
			sdo_oe_q <= 1'b0;
			wake_q   <= 1'b0;
		end else begin
			sck_oe_q <= is_master;
			sdo_oe_q <= is_master | slave_active;
			if (state_q != spi_port_pkg::ST_MASTER) begin
				sck_o_q <= clock_idle_polarity;
			end else if (tick && half_q < 5'(spi_port_pkg::HALF_STEPS)) begin
				sck_o_q <= ~sck_o_q;
			end
			wake_q <= SLEEP & ie_q & if_q;
		end
	end

	assign PRDATA  = prdata_q;
	assign PREADY  = pready_q;
	assign PSLVERR = pslverr_q;
	assign SCK_O   = sck_o_q;
	assign SCK_OE  = sck_oe_q;
	assign SDO_O   = sdo_q;
	assign SDO_OE  = sdo_oe_q;
	assign WAKE    = wake_q;

	// checks beside the logic
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RESET);

	a_word_len: assert property (done_word |->
		(bit_cnt_q + (sample ? 4'h1 : 4'h0)) == 4'(spi_port_pkg::WORD_BITS))
		else $error("word completed with wrong bit count");
	a_idle_level: assert property ($past(state_q != spi_port_pkg::ST_MASTER)
		&& state_q == spi_port_pkg::ST_IDLE |-> sck_o_q == $past(clock_idle_polarity))
		else $error("serial clock not at idle level");
	a_disable_quiet: assert property (!en |=>
		!sck_oe_q && !sdo_oe_q && state_q == spi_port_pkg::ST_IDLE)
		else $error("port active while disabled");
	a_busy_ignore: assert property (busy && wr_buf && !m_chg && !s_chg |=>
		tx_q == $past(tx_q))
		else $error("buffer write taken while busy");
	a_full_set: assert property (done_word && !(bf_q && is_slave) |=>
		bf_q && if_q && buf_q == $past(word_in))
		else $error("completed word not posted");
	a_ov_keep: assert property (done_word && bf_q && is_slave |=>
		ov_q && buf_q == $past(buf_q))
		else $error("overflow word not discarded");
	a_ov_master: assert property (is_master && !ov_q |=> !ov_q)
		else $error("overflow set as master");
	a_full_clear: assert property (rd_buf && !done_word |=> !bf_q)
		else $error("buffer read did not clear full");
	a_sel_release: assert property (is_slave && sel_mode && sce_n_s |=> !sdo_oe_q)
		else $error("data-out driven with select high");
	a_master_run: assert property (wr_buf && !busy && is_master ##1 is_master[*2]
		|-> busy && sck_oe_q)
		else $error("master transfer did not start");

	c_master_word: cover property (m_done);
	c_slave_word: cover property (s_done && !bf_q);
	c_overflow: cover property (done_word && bf_q && is_slave);
	c_wake: cover property (SLEEP && ie_q && $rose(if_q));
endmodule : spi_port

// ---- verilog/spi_port_pkg.sv ----
// spi_port_pkg: register map, field positions, reset values, modes and timing
// assumes a 100 MHz MCLK and a 32-bit APB register bus with byte addresses
package spi_port_pkg;
	// clock and serial clock rates, kept as times and turned into counts
	localparam int MCLK_PERIOD_NS = 10;
	localparam int CPU_HALF_NS    = 50;   // half period of sck on the processor clock
	localparam int LS_HALF_NS     = 500;  // half period of sck on the low-speed clock
	localparam int CPU_HALF_CYC   = (CPU_HALF_NS / MCLK_PERIOD_NS < 1) ? 1
		: CPU_HALF_NS / MCLK_PERIOD_NS;
	localparam int LS_HALF_CYC    = (LS_HALF_NS / MCLK_PERIOD_NS < 1) ? 1
		: LS_HALF_NS / MCLK_PERIOD_NS;
	// data in needs four cycles through the pin filter before a mid-bit sample sees it
	localparam int SYNC_HALF_MIN  = 5;

	// register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam logic [7:0] BUF_OFS  = 8'h08;
	localparam logic [7:0] INTC_OFS = 8'h0C;

	// field positions
	localparam int CTRL_EN_BIT   = 7;
	localparam int CTRL_CKP_BIT  = 6;
	localparam int CTRL_CKE_BIT  = 5;
	localparam int CTRL_SMP_BIT  = 4;
	localparam int CTRL_MODE_LSB = 0;
	localparam int STAT_BUSY_BIT = 7;
	localparam int STAT_OV_BIT   = 6;
	localparam int STAT_BF_BIT   = 0;
	localparam int INTC_IE_BIT   = 0;
	localparam int INTC_IF_BIT   = 1;

	// reset values and writable masks
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CTRL_MASK  = 8'hF3;
	localparam logic [7:0] BUF_RESET  = 8'h00;

	// transfer geometry
	localparam int WORD_BITS  = 8;
	localparam int HALF_STEPS = 16;

	typedef enum logic [1:0] {
		MODE_MASTER_LS  = 2'h0,
		MODE_MASTER_CPU = 2'h1,
		MODE_SLAVE      = 2'h2,
		MODE_SLAVE_SEL  = 2'h3
	} mode_type;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'h1,
		ST_MASTER = 3'h2,
		ST_SLAVE  = 3'h4
	} state_type;
endpackage : spi_port_pkg

// ---- verilog/pin_sync.sv ----
// pin_sync: three-flop synchroniser per bit with agreement filter
// assumes inputs asynchronous to clk; output changes once stages two and three agree
`timescale 1ns/100ps
module pin_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,    // sampling clock
	input  wire logic         rst,    // synchronous reset, active high
	input  wire logic [W-1:0] rst_val, // value taken at reset
	input  wire logic [W-1:0] d,      // asynchronous inputs
	output logic      [W-1:0] q       // filtered synchronous outputs
);
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic s1_q;
			logic s2_q;
			logic s3_q;
			// first stage feeds only the second; the filter looks at stages two and three
			always_ff @(posedge clk) begin
				s1_q <= d[i];
				s2_q <= s1_q;
				s3_q <= s2_q;
			end
			always_ff @(posedge clk) begin
				if (rst) begin
					q[i] <= rst_val[i]; // each pin starts at its rest level, so no false edge follows reset
				end else if (s2_q == s3_q) begin
					q[i] <= s3_q;
				end
			end
		end
	endgenerate
endmodule : pin_sync

// ---- tb/spi_peer_model.sv ----
// spi_peer_model: external serial peripheral answering the port in master mode
// assumes the port owns sck; a rising load marks the start of each frame
`timescale 1ns/100ps
module spi_peer_model (
	input  wire logic       sck,  // serial clock on the wire
	input  wire logic       sdo,  // data from the port
	input  wire logic       cpol, // idle level of sck
	input  wire logic       cke,  // 1: data changes on the trailing edge
	input  wire logic       load, // rising edge starts a frame
	input  wire logic [7:0] tx,   // word sent back
	output logic            sdi,  // data to the port
	output logic      [7:0] rx    // word taken from the port
);
	int n = 8;
	// frame start: msb is on the line before the first edge
	always @(posedge load) begin
		n = 0;
		sdi = tx[7];
	end
	// change on one edge, sample on the other; with cke 1 the line flips once after the last bit
	always @(sck) begin
		if (((sck !== cpol) ^ cke) && n < 8) begin
			sdi = (n + cke < 8) ? tx[7 - n - cke] : ~sdi;
			n++;
		end else
			rx = {rx[6:0], sdo};
	end
endmodule : spi_peer_model

// ---- tb/spi_port_test.sv ----
// spi_port_test: self-checking bench for the serial port over apb
// assumes spi_port_pkg; the bench plays the remote master in slave mode
`timescale 1ns/100ps
module spi_port_test;
	localparam logic [7:0] CT = spi_port_pkg::CTRL_OFS;
	localparam logic [7:0] ST = spi_port_pkg::STAT_OFS;
	localparam logic [7:0] BA = spi_port_pkg::BUF_OFS;
	localparam logic [7:0] IC = spi_port_pkg::INTC_OFS;
	logic        mclk, reset, psel, penable, pwrite, sleep, sck_tb, sdi_tb, sce_n, slv;
	logic        load, cpol, cke, pready, pslverr, wake, sck_o, sck_oe, sdo_o, sdo_oe;
	logic        peer_sdi, rd_e;
	logic [7:0]  paddr, ptx, prx;
	logic [31:0] pwdata, prdata, rd_d;
	int          num_errors, checks_done, cyc;
	wire         sck_w = sck_oe ? sck_o : sck_tb;
	wire         sdo_w = sdo_oe ? sdo_o : ~sdo_o; // a released line does not hold its value
	wire         sdi_w = slv ? sdi_tb : peer_sdi;

	spi_port #(.CPU_HALF(5), .LS_HALF(6)) uut (.MCLK(mclk), .RESET(reset), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .SLEEP(sleep), .WAKE(wake), .SCK_I(sck_w),
		.SCK_O(sck_o), .SCK_OE(sck_oe), .SDI(sdi_w), .SDO_O(sdo_o), .SDO_OE(sdo_oe),
		.SCE_N(sce_n));
	spi_peer_model peer (.sck(sck_w), .sdo(sdo_w), .cpol(cpol), .cke(cke), .load(load),
		.tx(ptx), .sdi(peer_sdi), .rx(prx));

	// 100 mhz system clock
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// hang guard, far above the thousand or so cycles the run needs
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 30000) begin
			num_errors++;
			summarize();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check
	// one apb transfer; the request is held until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd_d = prdata;
		rd_e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wait_idle();
		for (int i = 0; i < 100; i++) begin
			apb(1'b0, ST, 32'h0);
			if (rd_d[7] === 1'b0) break;
		end
	endtask : wait_idle
	// remote master frame, cpol 0 cke 1, 80 ns clock running only inside the frame
	task automatic slave_xfer(input logic [7:0] mo, output logic [7:0] mi);
		repeat (8) @(posedge mclk);
		for (int i = 7; i >= 0; i--) begin
			sdi_tb <= mo[i];
			repeat (4) @(posedge mclk);
			sck_tb <= 1'b1;
			repeat (4) @(posedge mclk);
			mi[i] = sdo_w;
			sck_tb <= 1'b0;
		end
		sdi_tb <= ~mo[0];
		repeat (12) @(posedge mclk);
	endtask : slave_xfer

	task automatic test_regs();
		apb(1'b0, CT, 32'h0);
		check(rd_d, {24'h0, spi_port_pkg::CTRL_RESET}, "ctrl reset");
		apb(1'b1, CT, 32'h7F);
		apb(1'b0, CT, 32'h0);
		check(rd_d, 32'h73, "ctrl mask");
		apb(1'b1, 8'h10, 32'h5);
		check(rd_e, 1'b1, "unmapped write");
		apb(1'b0, 8'h10, 32'h0);
		check(rd_e, 1'b1, "unmapped read error");
		check(rd_d, 32'h0, "unmapped read data");
		apb(1'b1, BA, 32'h55);
		repeat (40) @(posedge mclk);
		check({sck_oe, sdo_oe}, 2'b00, "disabled pins");
		apb(1'b0, ST, 32'h0);
		check(rd_d, 32'h00, "no transfer");
	endtask : test_regs
	// table of {cpol, cke, smp, mode}; the second word is left unread on purpose
	task automatic test_master();
		logic [4:0] cfg [4] = '{5'b01001, 5'b11101, 5'b00101, 5'b10000};
		for (int i = 0; i < 4; i++) begin
			cpol <= cfg[i][4];
			cke  <= cfg[i][3];
			ptx  <= 8'hA5 ^ 8'(i);
			apb(1'b1, CT, {24'h0, 1'b1, cfg[i][4], cfg[i][3], cfg[i][2], 2'h0,
				cfg[i][1:0]});
			// the new rest level reaches the wire first, so the peer sees no false edge
			repeat (2) @(posedge mclk);
			load <= 1'b1;
			apb(1'b1, BA, {24'h0, 8'h3C + 8'(i)});
			load <= 1'b0;
			if (i == 0) begin
				apb(1'b0, ST, 32'h0);
				check(rd_d[7], 1'b1, "busy");
				apb(1'b1, BA, 32'hFF);
			end
			wait_idle();
			check(sck_o, cfg[i][4], "sck idle");
			check(sck_oe, 1'b1, "sck driven");
			check(prx, 8'h3C + 8'(i), "peer rx");
			apb(1'b0, ST, 32'h0);
			check(rd_d, 32'h01, "stat");
			apb(1'b0, IC, 32'h0);
			check(rd_d[1], 1'b1, "flag");
			apb(1'b1, IC, 32'h0);
			if (i != 1) begin
				apb(1'b0, BA, 32'h0);
				check(rd_d, {24'h0, 8'hA5 ^ 8'(i)}, "buf");
			end
		end
	endtask : test_master
	task automatic test_slave();
		logic [7:0] mi;
		slv   <= 1'b1;
		sleep <= 1'b1;
		// park the port while the wire falls to the slave rest level
		apb(1'b1, CT, 32'h00);
		repeat (8) @(posedge mclk);
		apb(1'b1, CT, 32'hA2);
		apb(1'b1, IC, 32'h01);
		check(sck_oe, 1'b0, "sck input");
		apb(1'b1, BA, 32'h5A);
		slave_xfer(8'hC3, mi);
		check(mi, 8'h5A, "slave out");
		check(wake, 1'b1, "wake");
		apb(1'b1, BA, 32'h69);
		slave_xfer(8'h96, mi);
		check(mi, 8'h69, "second out");
		apb(1'b0, ST, 32'h0);
		check(rd_d, 32'h41, "overflow");
		apb(1'b0, BA, 32'h0);
		check(rd_d, 32'hC3, "kept word");
		apb(1'b0, ST, 32'h0);
		check(rd_d, 32'h40, "bf cleared");
		apb(1'b1, ST, 32'h0);
		apb(1'b1, IC, 32'h01);
		apb(1'b0, ST, 32'h0);
		check(rd_d, 32'h00, "ov cleared");
		check(wake, 1'b0, "wake gone");
	endtask : test_slave
	task automatic test_select();
		logic [7:0] mi;
		sce_n <= 1'b1;
		apb(1'b1, CT, 32'hA3);
		apb(1'b1, BA, 32'h11);
		check(sdo_oe, 1'b0, "sdo released");
		slave_xfer(8'h77, mi);
		apb(1'b0, ST, 32'h0);
		check(rd_d, 32'h00, "no word");
		sce_n <= 1'b0;
		repeat (8) @(posedge mclk);
		apb(1'b1, BA, 32'h11);
		check(sdo_oe, 1'b1, "sdo driven");
		slave_xfer(8'h3A, mi);
		check(mi, 8'h11, "select out");
		apb(1'b0, BA, 32'h0);
		check(rd_d, 32'h3A, "select word");
		apb(1'b1, CT, 32'h00);
		repeat (2) @(posedge mclk);
		check({sck_oe, sdo_oe}, 2'b00, "disabled");
	endtask : test_select

	task automatic summarize();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : summarize

	// reset for ten cycles, then the scenarios in turn
	initial begin
		{reset, psel, penable, pwrite, sleep, sck_tb, sdi_tb, slv, load, cpol, cke} = 11'h400;
		sce_n  = 1'b0;
		paddr  = 8'h00;
		pwdata = 32'h0;
		ptx    = 8'h00;
		repeat (10) @(posedge mclk);
		reset <= 1'b0;
		test_regs();
		test_master();
		test_slave();
		test_select();
		summarize();
	end
endmodule : spi_port_test
